// file: hdl/smp_params.svh
// Constants of the symbol serializer and line coder core.
// Included by the package and by the design file; definitions only.
`ifndef SMP_PARAMS_SVH
`define SMP_PARAMS_SVH

`define SMP_SYM_BITS 5
`define SMP_SYM_RATE_MHZ 25
`define SMP_BIT_RATE_MHZ 125
`define SMP_BITS_PER_SYM (`SMP_BIT_RATE_MHZ / `SMP_SYM_RATE_MHZ)
`define SMP_LAST_PHASE 3'h4
`define SMP_CLK_HIGH_PHASES 3'h2
`define SMP_TX_PHASE_RST 3'h4
`define SMP_RX_PHASE_RST 3'h3
`define SMP_IDLE_SYM 5'h1f
`define SMP_FIFO_DEPTH 4
`define SMP_SD_WINDOW 5'h10

`endif

// file: hdl/smp_pkg.sv
// Types shared by the symbol serializer and line coder core.
// Assumes smp_params.svh is on the include path.
`include "smp_params.svh"

package smp_pkg;

  // Three-level line state, one-hot; two zero states remember the next direction
  typedef enum logic [3:0] {
    SMP_LVL_ZP  = 4'b0001,
    SMP_LVL_POS = 4'b0010,
    SMP_LVL_ZN  = 4'b0100,
    SMP_LVL_NEG = 4'b1000
  } smp_level_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } smp_line_t;

  typedef struct packed {
    logic [2:0] tx_phase;
    logic [`SMP_SYM_BITS-1:0] tx_shift;
    smp_level_t tx_level;
    smp_line_t line_out;
    logic tx_sym_clk;
    logic [2:0] rx_phase;
    logic [`SMP_SYM_BITS-1:0] rx_shift;
    logic [`SMP_SYM_BITS-1:0] rx_sym;
    logic rx_clk;
    smp_line_t rx_prev;
    logic [4:0] sd_count;
    logic sd;
  } smp_state_t;

endpackage

// file: hdl/smp_phy.sv
// Symbol FIFO and top of the symbol serializer / MLT-3 line coder core.
// Assumes CORE_CLK is the bit clock and line inputs are already equalized levels.
//
// Behaviour
// - transmit takes one scrambled 5-bit symbol per symbol period, no further coding.
// - bit clock runs at five times the symbol clock; symbol clock is derived by division.
// - each symbol leaves serially, one bit per bit clock, no gaps between symbols.
// - serial transmit bits are MLT-3 coded before driving the line output.
// - receive decodes MLT-3 to NRZ and delivers scrambled 5-bit symbols.
// - received bits deserialize on recovered clock; divided clock goes out with symbols.
// - loopback input low selects loopback, high selects normal operation.
// - in loopback the coded transmit stream feeds the receive path.
// - signal detect is active only in 100 Mbit mode.
// - speed select low chooses 100 Mbit, high chooses 10 Mbit.
// - in 10 Mbit mode the line carries the legacy transmit input.
`timescale 1ns/1ps
`include "smp_params.svh"
`default_nettype none

// ****************************************
// Symbol FIFO
// ****************************************
module smp_fifo #(
  parameter int WIDTH = `SMP_SYM_BITS,
  parameter int DEPTH = `SMP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] count;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic ready;
  } smp_fifo_state_t;

  smp_fifo_state_t f;
  smp_fifo_state_t next_f;
  logic push;
  logic pop;

  assign push = in_valid && f.ready;
  assign pop = out_ready && (f.count != '0);
  assign in_ready = f.ready;
  assign out_valid = (f.count != '0);
  assign out_data = f.mem[f.rd];

  always_comb begin
    next_f = f;
    if (push) begin
      next_f.mem[f.wr] = in_data;
      next_f.wr = (f.wr == AW'(DEPTH - 1)) ? '0 : f.wr + 1'b1;
    end
    if (pop) begin
      next_f.rd = (f.rd == AW'(DEPTH - 1)) ? '0 : f.rd + 1'b1;
    end
    next_f.count = f.count + (AW+1)'(push) - (AW+1)'(pop);
    next_f.ready = (next_f.count < (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f <= '0;
      f.ready <= 1'b1;
    end else begin
      f <= next_f;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_fifo_no_overrun: assert property (f.count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

// ****************************************
// Top
// ****************************************
module smp_phy (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Transmit symbols
  input wire logic [`SMP_SYM_BITS-1:0] TX_SYMBOL_IN,
  input wire logic TX_SYMBOL_VALID,
  output logic TX_READY,
  output logic TX_SYMBOL_CLOCK,
  // Receive symbols
  output logic [`SMP_SYM_BITS-1:0] RX_SYMBOL_OUT,
  output logic RX_RECOVERED_CLOCK,
  // Line
  input wire smp_pkg::smp_line_t LINE_IN,
  input wire smp_pkg::smp_line_t LEGACY_TX_IN,
  output smp_pkg::smp_line_t LINE_OUT,
  // Control and status
  input wire logic LOOPBACK_N,
  input wire logic SPEED_SELECT,
  output logic SIGNAL_DETECT_OUT
);

  smp_pkg::smp_state_t s;
  smp_pkg::smp_state_t next_s;
  logic fifo_valid;
  logic [`SMP_SYM_BITS-1:0] fifo_data;
  logic load;
  logic tx_bit;
  logic nrz;
  smp_pkg::smp_line_t rx_level;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic smp_pkg::smp_level_t mlt3_step(smp_pkg::smp_level_t lv, logic b);
    mlt3_step = lv;
    if (b) begin
      unique case (lv)
        smp_pkg::SMP_LVL_ZP: mlt3_step = smp_pkg::SMP_LVL_POS;
        smp_pkg::SMP_LVL_POS: mlt3_step = smp_pkg::SMP_LVL_ZN;
        smp_pkg::SMP_LVL_ZN: mlt3_step = smp_pkg::SMP_LVL_NEG;
        smp_pkg::SMP_LVL_NEG: mlt3_step = smp_pkg::SMP_LVL_ZP;
        default: mlt3_step = smp_pkg::SMP_LVL_ZP;
      endcase
    end
  endfunction

  function automatic smp_pkg::smp_line_t level_pins(smp_pkg::smp_level_t lv);
    level_pins.pos = (lv == smp_pkg::SMP_LVL_POS);
    level_pins.neg = (lv == smp_pkg::SMP_LVL_NEG);
  endfunction

  function automatic logic [2:0] phase_next(logic [2:0] p);
    phase_next = (p == `SMP_LAST_PHASE) ? 3'h0 : p + 3'h1;
  endfunction

  smp_fifo #(
    .WIDTH(`SMP_SYM_BITS),
    .DEPTH(`SMP_FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst(RST),
    .in_valid(TX_SYMBOL_VALID),
    .in_data(TX_SYMBOL_IN),
    .in_ready(TX_READY),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(load)
  );

  // ****************************************
  // Datapath
  // ****************************************
  assign load = (s.tx_phase == `SMP_LAST_PHASE);
  assign tx_bit = s.tx_shift[`SMP_SYM_BITS-1];
  // Loopback feeds the coded transmit level straight into the receiver
  assign rx_level = LOOPBACK_N ? LINE_IN : level_pins(s.tx_level);
  assign nrz = (rx_level != s.rx_prev);

  always_comb begin
    next_s = s;
    next_s.tx_phase = phase_next(s.tx_phase);
    if (load) begin
      next_s.tx_shift = fifo_valid ? fifo_data : `SMP_IDLE_SYM;
    end else begin
      next_s.tx_shift = {s.tx_shift[`SMP_SYM_BITS-2:0], 1'b0};
    end
    next_s.tx_level = mlt3_step(s.tx_level, tx_bit);
    next_s.line_out = SPEED_SELECT ? LEGACY_TX_IN : level_pins(next_s.tx_level);
    next_s.tx_sym_clk = (next_s.tx_phase < `SMP_CLK_HIGH_PHASES);
    next_s.rx_prev = rx_level;
    next_s.rx_phase = phase_next(s.rx_phase);
    next_s.rx_shift = {s.rx_shift[`SMP_SYM_BITS-2:0], nrz};
    if (s.rx_phase == `SMP_LAST_PHASE) begin
      next_s.rx_sym = {s.rx_shift[`SMP_SYM_BITS-2:0], nrz};
    end
    next_s.rx_clk = (next_s.rx_phase < `SMP_CLK_HIGH_PHASES);
    if (nrz) begin
      next_s.sd_count = 5'h0;
    end else if (s.sd_count != `SMP_SD_WINDOW) begin
      next_s.sd_count = s.sd_count + 5'h1;
    end
    next_s.sd = !SPEED_SELECT && (next_s.sd_count != `SMP_SD_WINDOW);
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
      // First symbol clock edge comes with the first load; no short first period
      // Receive framing trails transmit by one bit, so looped symbols land aligned
      s.tx_phase <= `SMP_TX_PHASE_RST;
      s.rx_phase <= `SMP_RX_PHASE_RST;
      s.tx_shift <= `SMP_IDLE_SYM;
      s.tx_level <= smp_pkg::SMP_LVL_ZP;
      s.sd_count <= `SMP_SD_WINDOW;
    end else begin
      s <= next_s;
    end
  end

  assign TX_SYMBOL_CLOCK = s.tx_sym_clk;
  assign RX_SYMBOL_OUT = s.rx_sym;
  assign RX_RECOVERED_CLOCK = s.rx_clk;
  assign LINE_OUT = s.line_out;
  assign SIGNAL_DETECT_OUT = s.sd;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_sym_start;
    $rose(s.tx_sym_clk);
  endsequence

  sequence s_step_from_zn;
    tx_bit && s.tx_level == smp_pkg::SMP_LVL_ZN && !SPEED_SELECT;
  endsequence

  a_sym_period: assert property (s_sym_start |-> ##5 $rose(s.tx_sym_clk))
    else $error("symbol clock period is not five bit clocks");
  a_load_msb: assert property ($past(load) && $past(fifo_valid) |->
    s.tx_shift == $past(fifo_data)) else $error("accepted symbol not loaded");
  a_shift_gapless: assert property (!load |=> s.tx_shift[4:1] == $past(s.tx_shift[3:0]))
    else $error("serial shift skipped a bit");
  a_mlt3_hold: assert property (!tx_bit |=> s.tx_level == $past(s.tx_level))
    else $error("line level moved on a zero bit");
  a_mlt3_step: assert property (s_step_from_zn |=>
    s.tx_level == smp_pkg::SMP_LVL_NEG && s.line_out.neg)
    else $error("line level did not step to minus");
  a_legacy_path: assert property (SPEED_SELECT |=> LINE_OUT == $past(LEGACY_TX_IN))
    else $error("10 Mbit line does not carry legacy input");
  a_sd_10m: assert property (SPEED_SELECT |=> !SIGNAL_DETECT_OUT)
    else $error("signal detect active in 10 Mbit mode");
  a_rx_deser: assert property (s.rx_phase == `SMP_LAST_PHASE |=>
    RX_SYMBOL_OUT == {$past(s.rx_shift[3:0]), $past(nrz)} && RX_RECOVERED_CLOCK)
    else $error("received symbol not deserialized in order");
  a_loop_route: assert property (!LOOPBACK_N && !$past(LOOPBACK_N) |->
    nrz == $past(tx_bit)) else $error("loopback does not feed the receiver");
endmodule

`default_nettype wire

// file: verification/smp_mac_model.sv
// Controller model: offers transmit symbols and holds each until it is taken, for at most 50 clocks.
// Assumes the bench calls offer() and that clk is the core bit clock.
`timescale 1ns/1ps
`include "smp_params.svh"
`default_nettype none
module smp_mac_model (
  // Clock
  input wire logic clk,
  // Symbol side
  input wire logic ready,
  output logic [`SMP_SYM_BITS-1:0] sym,
  output logic valid
);
  initial begin
    sym = 5'h00;
    valid = 1'b0;
  end
  // Hold the offer through the edge that sees ready; the released bus shows the inverse
  task automatic offer(input logic [`SMP_SYM_BITS-1:0] s, output bit ok);
    ok = 0;
    @(posedge clk);
    sym <= s;
    valid <= 1'b1;
    for (int i = 0; i < 50 && !ok; i++) begin
      #1;
      ok = (ready === 1'b1);
      @(posedge clk);
    end
    valid <= 1'b0;
    sym <= ~s;
  endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Bench for the symbol serializer and line coder core.
// Assumes the design package, design file and controller model are compiled first.
`timescale 1ns/1ps
`include "smp_params.svh"
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [4:0] sym;
    logic [4:0] rx;
  } smp_row_t;
  logic CORE_CLK = 1'b0, RST = 1'b1, LOOPBACK_N = 1'b1, SPEED_SELECT = 1'b0;
  logic [4:0] tx_sym, rx_sym;
  logic tx_valid, tx_ready, tx_clk, rx_clk, sd;
  smp_pkg::smp_line_t line_in = '0, legacy = '0, line_out, rx_lvl = '0;
  bit tx_dir, rx_dir, ok, saw_full;
  int num_errors = 0, samples_checked = 0;
  smp_row_t rows [7] = '{10'h000, 10'h3ff, 10'h2b5, 10'h14a, 10'h210, 10'h021, 10'h273};

  smp_phy i_smp_phy (.CORE_CLK(CORE_CLK), .RST(RST), .TX_SYMBOL_IN(tx_sym),
    .TX_SYMBOL_VALID(tx_valid), .TX_READY(tx_ready), .TX_SYMBOL_CLOCK(tx_clk),
    .RX_SYMBOL_OUT(rx_sym), .RX_RECOVERED_CLOCK(rx_clk), .LINE_IN(line_in),
    .LEGACY_TX_IN(legacy), .LINE_OUT(line_out), .LOOPBACK_N(LOOPBACK_N),
    .SPEED_SELECT(SPEED_SELECT), .SIGNAL_DETECT_OUT(sd));
  smp_mac_model i_smp_mac_model (.clk(CORE_CLK), .ready(tx_ready), .sym(tx_sym),
    .valid(tx_valid));

  initial forever #10 CORE_CLK = ~CORE_CLK;

  // Records that the transmit buffer pushed back at least once
  always @(posedge CORE_CLK)
    if (!RST && tx_ready === 1'b0) saw_full <= 1'b1;

  // Direction of the next line step, taken from the last nonzero level seen
  always @(posedge CORE_CLK or posedge RST)
    if (RST) tx_dir <= 1'b0;
    else if (line_out.pos) tx_dir <= 1'b1;
    else if (line_out.neg) tx_dir <= 1'b0;

  function automatic smp_pkg::smp_line_t mlt3(smp_pkg::smp_line_t cur, bit dir, logic b);
    if (!b) return cur;
    if (cur.pos || cur.neg) return '0;
    return dir ? 2'b01 : 2'b10;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rise(input bit rx);
    logic last;
    last = rx ? rx_clk : tx_clk;
    for (int i = 0; i < 20; i++) begin
      @(posedge CORE_CLK);
      #1;
      if ((rx ? rx_clk : tx_clk) === 1'b1 && last === 1'b0) return;
      last = rx ? rx_clk : tx_clk;
    end
    num_errors++;
    print_verdict();
  endtask

  initial begin
    smp_pkg::smp_line_t exp;
    repeat (16) @(posedge CORE_CLK);
    #1;
    check({4'h0, tx_ready}, 5'h01);
    check({3'h0, line_out}, 5'h00);
    check(rx_sym, 5'h00);
    check({4'h0, sd}, 5'h00);
    @(posedge CORE_CLK);
    RST <= 1'b0;
    $display("test reset done");
    foreach (rows[r]) begin
      wait_rise(0);
      i_smp_mac_model.offer(rows[r].sym, ok);
      if (!ok) begin
        num_errors++;
        print_verdict();
      end
      wait_rise(0);
      for (int i = 4; i >= 0; i--) begin
        exp = mlt3(line_out, tx_dir, rows[r].sym[i]);
        @(posedge CORE_CLK);
        #1;
        check({3'h0, line_out}, {3'h0, exp});
      end
      wait_rise(1);
      repeat (4) @(posedge CORE_CLK);
      for (int i = 4; i >= 0; i--) begin
        @(posedge CORE_CLK);
        rx_lvl = mlt3(rx_lvl, rx_dir, rows[r].rx[i]);
        if (rx_lvl.pos) rx_dir = 1'b1;
        else if (rx_lvl.neg) rx_dir = 1'b0;
        line_in <= rx_lvl;
      end
      @(posedge CORE_CLK);
      #1;
      check(rx_sym, rows[r].rx);
      check({4'h0, rx_clk}, 5'h01);
    end
    $display("test rows done");
    repeat (20) @(posedge CORE_CLK);
    #1;
    check({4'h0, sd}, 5'h00);
    @(posedge CORE_CLK);
    LOOPBACK_N <= 1'b0;
    repeat (20) @(posedge CORE_CLK);
    #1;
    check(rx_sym, `SMP_IDLE_SYM);
    check({4'h0, sd}, 5'h01);
    wait_rise(0);
    i_smp_mac_model.offer(5'h0a, ok);
    check({4'h0, ok}, 5'h01);
    wait_rise(0);
    wait_rise(1);
    wait_rise(1);
    check(rx_sym, 5'h0a);
    $display("test loopback done");
    @(posedge CORE_CLK);
    SPEED_SELECT <= 1'b1;
    legacy <= 2'b10;
    repeat (3) @(posedge CORE_CLK);
    #1;
    check({3'h0, line_out}, 5'h02);
    check({4'h0, sd}, 5'h00);
    $display("test legacy mode done");
    for (int n = 0; n < 8; n++) begin
      i_smp_mac_model.offer(5'h1e, ok);
      check({4'h0, ok}, 5'h01);
    end
    check({4'h0, saw_full}, 5'h01);
    $display("test buffer full done");
    print_verdict();
  end
endmodule
`default_nettype wire
